// [inc/hbss_defs.vh]
`ifndef HBSS_DEFS_VH
`define HBSS_DEFS_VH

`define HBSS_PORTS 6
`define HBSS_GPIOS 8

// six-level resistor codes, lowest resistance pull-up last
`define HBSS_CODE_200K_PD 3'h0
`define HBSS_CODE_200K_PU 3'h1
`define HBSS_CODE_10K_PD 3'h2
`define HBSS_CODE_10K_PU 3'h3
`define HBSS_CODE_10R_PD 3'h4
`define HBSS_CODE_10R_PU 3'h5

// fixed-port masks, bit 0 is port 1
`define HBSS_FIXED_NONE 6'h00
`define HBSS_FIXED_P2 6'h02
`define HBSS_FIXED_P23 6'h06
`define HBSS_FIXED_P24 6'h0e
`define HBSS_FIXED_P25 6'h1e
`define HBSS_FIXED_P26 6'h3e

// charging-port masks
`define HBSS_CHG_NONE 6'h00
`define HBSS_CHG_P1 6'h01
`define HBSS_CHG_P12 6'h03
`define HBSS_CHG_P13 6'h07
`define HBSS_CHG_P14 6'h0f
`define HBSS_CHG_P16 6'h3f

// defaults held in internal rom
`define HBSS_ROM_PORT_DIS 6'h00
`define HBSS_ROM_FIXED 6'h00
`define HBSS_ROM_CHG 6'h00
`define HBSS_ROM_GPIO_CFG 3'h0

// boot flash signature and addresses
`define HBSS_SIG_ADDR 16'hfffa
`define HBSS_EXEC_ADDR 16'h0000
`define HBSS_SIG_B0 8'h32
`define HBSS_SIG_B1 8'h44
`define HBSS_SIG_B2 8'h46
`define HBSS_SIG_B3 8'h55

// internal register addresses
`define HBSS_REG_CFG_END 8'hff
`define HBSS_REG_GPIO_BASE 8'h10

// gpio config fields: [1:0] mode, [2] output level
`define HBSS_GPIO_IN 2'h0
`define HBSS_GPIO_IN_PD 2'h1
`define HBSS_GPIO_IN_PU 2'h2
`define HBSS_GPIO_OUT 2'h3
`define HBSS_GPIO_LVL_BIT 2

// cycles of settling after reset release before straps are taken
`define HBSS_SETTLE_CYCLES 3'h4

`endif

// [rtl/hbss_pin_sync.v]
`timescale 1ns/10ps
module hbss_pin_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire reset_n,
    input wire [WIDTH-1:0] pinIn,
    output reg [WIDTH-1:0] pinStable
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge clk) begin
                if (!reset_n) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                    stage3[i] <= 1'b0;
                    pinStable[i] <= 1'b0;
                end else begin
                    stage1[i] <= pinIn[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                    // a change only counts once two settled stages agree
                    if (stage2[i] == stage3[i]) begin
                        pinStable[i] <= stage3[i];
                    end
                end
            end
        end
    endgenerate
endmodule

// [rtl/hbss_sequencer.v]
// Notes on behaviour
// - each port has one disable strap per data line; 1 marks that line disabled.
// - a downstream port is disabled only when both its line straps read high.
// - a strap-disabled port also loses its SuperSpeed function.
// - fixed-port code selects none, port 2, or ports 2 up to 3, 4, 5, 6.
// - charging code selects none, port 1, ports 1-2, 1-3, 1-4 or 1-6.
// - each gpio is input with optional pull-down or pull-up, or a driven output.
// - while enumerated, gpio setup is written by smbus or by usb bridging requests.
// - chip reset low means standby, high means hub mode.
// - standby disables ports, floats data pins, drops state, halts pll, keeps nothing.
// - in standby nothing runs except watching the chip reset.
// - after release: reset logic, wait pll lock, load default configuration registers.
// - spi mode reads signature at 0xfffa; match boots external from 0x0000.
// - without spi mode strap, skip flash check and go to configuration read.
// - boot flash is 1 Mbit, 60 MHz or faster; single or dual bit, modes 0/3.
// - configuration read loads rom defaults, then straps override them.
// - smbus code with both pins pulled up enters controller config, else otp merge.
// - the 200k pull-up configuration code selects smbus slave hub configuration.
// - straps are latched after settling once the pll locks, and kept afterwards.
// - controller configuration waits forever until register 0xff is written.
`timescale 1ns/10ps
`include "hbss_defs.vh"
module hbss_sequencer (
    input wire clk,
    input wire reset_n,
    input wire [5:0] port_plus_line_disable,
    input wire [5:0] port_minus_line_disable,
    input wire [2:0] fixed_port_select_strap,
    input wire [2:0] charging_port_select_strap,
    input wire [2:0] configStrapCode,
    input wire spiModeStrap,
    input wire smbusDataPullUp,
    input wire smbusClockPullUp,
    input wire pllLocked,
    input wire flashAck,
    input wire [7:0] flashData,
    input wire hostEnumerated,
    input wire smbusWriteValid,
    input wire [7:0] smbusWriteAddr,
    input wire [7:0] smbusWriteData,
    input wire bridgeWriteValid,
    input wire [7:0] bridgeWriteAddr,
    input wire [7:0] bridgeWriteData,
    input wire [7:0] gpioPinIn,
    output reg [7:0] bootStage,
    output reg pllEnable,
    output reg usbDataDriveEnable,
    output reg flashReadReq,
    output reg [15:0] flashReadAddr,
    output reg externalBoot,
    output reg [15:0] execAddr,
    output reg [5:0] portDisabled,
    output reg [5:0] superSpeedDisabled,
    output reg [5:0] fixedPorts,
    output reg [5:0] chargingPorts,
    output reg smbusSlaveMode,
    output reg configDone,
    output reg [7:0] gpioOut,
    output reg [7:0] gpioOe,
    output reg [7:0] gpioPullUp,
    output reg [7:0] gpioPullDown,
    output reg [7:0] gpioLevel
);
    localparam ST_STANDBY = 8'h01;
    localparam ST_INIT = 8'h02;
    localparam ST_SPI_CHECK = 8'h04;
    localparam ST_CFG_RD = 8'h08;
    localparam ST_STRAP = 8'h10;
    localparam ST_SOC_CFG = 8'h20;
    localparam ST_OTP_CFG = 8'h40;
    localparam ST_RUN = 8'h80;

    wire [24:0] strapSynced;
    wire [7:0] gpioSynced;

    // analogue and pin levels come from outside the clock domain
    hbss_pin_sync #(.WIDTH(25)) u_strapSync (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn({pllLocked, smbusClockPullUp, smbusDataPullUp, spiModeStrap, configStrapCode,
            charging_port_select_strap, fixed_port_select_strap, port_minus_line_disable,
            port_plus_line_disable}),
        .pinStable(strapSynced)
    );

    hbss_pin_sync #(.WIDTH(8)) u_gpioSync (
        .clk(clk),
        .reset_n(reset_n),
        .pinIn(gpioPinIn),
        .pinStable(gpioSynced)
    );

    reg [7:0] state;
    reg [2:0] settleCount;
    reg [1:0] sigIndex;
    reg sigMismatch;
    reg cfgRdOverride;
    reg [20:0] strapLatch;
    reg [2:0] gpioCfg [0:7];

    wire [5:0] latchPlus = strapLatch[5:0];
    wire [5:0] latchMinus = strapLatch[11:6];
    wire [2:0] latchFixed = strapLatch[14:12];
    wire [2:0] latchChg = strapLatch[17:15];
    wire [2:0] latchCfg = strapLatch[20:18];
    wire smbClkNow = strapSynced[23];
    wire smbDataNow = strapSynced[22];
    wire pllLockedSync = strapSynced[24];

    function [5:0] decodeFixed;
        input [2:0] code;
        begin
            case (code)
                `HBSS_CODE_200K_PU: decodeFixed = `HBSS_FIXED_P2;
                `HBSS_CODE_10K_PD: decodeFixed = `HBSS_FIXED_P23;
                `HBSS_CODE_10K_PU: decodeFixed = `HBSS_FIXED_P24;
                `HBSS_CODE_10R_PD: decodeFixed = `HBSS_FIXED_P25;
                `HBSS_CODE_10R_PU: decodeFixed = `HBSS_FIXED_P26;
                default: decodeFixed = `HBSS_FIXED_NONE;
            endcase
        end
    endfunction

    function [5:0] decodeCharging;
        input [2:0] code;
        begin
            case (code)
                `HBSS_CODE_200K_PU: decodeCharging = `HBSS_CHG_P1;
                `HBSS_CODE_10K_PD: decodeCharging = `HBSS_CHG_P12;
                `HBSS_CODE_10K_PU: decodeCharging = `HBSS_CHG_P13;
                `HBSS_CODE_10R_PD: decodeCharging = `HBSS_CHG_P14;
                `HBSS_CODE_10R_PU: decodeCharging = `HBSS_CHG_P16;
                default: decodeCharging = `HBSS_CHG_NONE;
            endcase
        end
    endfunction

    function [7:0] sigByte;
        input [1:0] idx;
        begin
            case (idx)
                2'h0: sigByte = `HBSS_SIG_B0;
                2'h1: sigByte = `HBSS_SIG_B1;
                2'h2: sigByte = `HBSS_SIG_B2;
                default: sigByte = `HBSS_SIG_B3;
            endcase
        end
    endfunction

    // smbus wins when both sources write in the same cycle
    wire smbAllowed = (state == ST_SOC_CFG) || (state == ST_RUN && hostEnumerated);
    wire bridgeAllowed = (state == ST_RUN) && hostEnumerated;
    wire smbWr = smbusWriteValid && smbAllowed;
    wire bridgeWr = bridgeWriteValid && bridgeAllowed && !smbWr;
    wire anyWr = smbWr || bridgeWr;
    wire [7:0] wrAddr = smbWr ? smbusWriteAddr : bridgeWriteAddr;
    wire [7:0] wrData = smbWr ? smbusWriteData : bridgeWriteData;
    wire [7:0] gpioIndex = wrAddr - `HBSS_REG_GPIO_BASE;
    wire gpioHit = anyWr && (wrAddr >= `HBSS_REG_GPIO_BASE) && (gpioIndex < 8'h08);

    always @(posedge clk) begin
        if (!reset_n) begin
            // standby: everything back to default, nothing retained
            state <= ST_STANDBY;
            settleCount <= 3'h0;
            sigIndex <= 2'h0;
            sigMismatch <= 1'b0;
            cfgRdOverride <= 1'b0;
            strapLatch <= 21'h0;
            bootStage <= ST_STANDBY;
            pllEnable <= 1'b0;
            usbDataDriveEnable <= 1'b0;
            flashReadReq <= 1'b0;
            flashReadAddr <= 16'h0000;
            externalBoot <= 1'b0;
            execAddr <= 16'h0000;
            portDisabled <= 6'h3f;
            superSpeedDisabled <= 6'h3f;
            fixedPorts <= 6'h00;
            chargingPorts <= 6'h00;
            smbusSlaveMode <= 1'b0;
            configDone <= 1'b0;
        end else begin
            bootStage <= state;
            case (state)
                ST_STANDBY: begin
                    pllEnable <= 1'b1;
                    settleCount <= 3'h0;
                    state <= ST_INIT;
                end
                ST_INIT: begin
                    // wait for the strap synchronisers to fill and the pll to lock
                    if (settleCount != `HBSS_SETTLE_CYCLES) begin
                        settleCount <= settleCount + 3'h1;
                    end else if (pllLockedSync) begin
                        strapLatch <= strapSynced[20:0];
                        portDisabled <= `HBSS_ROM_PORT_DIS;
                        superSpeedDisabled <= `HBSS_ROM_PORT_DIS;
                        fixedPorts <= `HBSS_ROM_FIXED;
                        chargingPorts <= `HBSS_ROM_CHG;
                        if (strapSynced[21]) begin
                            sigIndex <= 2'h0;
                            sigMismatch <= 1'b0;
                            flashReadAddr <= `HBSS_SIG_ADDR;
                            flashReadReq <= 1'b1;
                            state <= ST_SPI_CHECK;
                        end else begin
                            state <= ST_CFG_RD;
                        end
                    end
                end
                ST_SPI_CHECK: begin
                    // flash engine handles single/dual bit and clock mode; one byte per ack
                    if (flashReadReq && flashAck) begin
                        if (flashData != sigByte(sigIndex)) begin
                            sigMismatch <= 1'b1;
                        end
                        if (sigIndex == 2'h3) begin
                            flashReadReq <= 1'b0;
                            if (!sigMismatch && flashData == sigByte(sigIndex)) begin
                                externalBoot <= 1'b1;
                                execAddr <= `HBSS_EXEC_ADDR;
                            end
                            state <= ST_CFG_RD;
                        end else begin
                            sigIndex <= sigIndex + 2'h1;
                            flashReadAddr <= flashReadAddr + 16'h0001;
                        end
                    end
                end
                ST_CFG_RD: begin
                    if (!cfgRdOverride) begin
                        cfgRdOverride <= 1'b1;
                        portDisabled <= `HBSS_ROM_PORT_DIS;
                        superSpeedDisabled <= `HBSS_ROM_PORT_DIS;
                        fixedPorts <= `HBSS_ROM_FIXED;
                        chargingPorts <= `HBSS_ROM_CHG;
                    end else begin
                        portDisabled <= latchPlus & latchMinus;
                        superSpeedDisabled <= latchPlus & latchMinus;
                        fixedPorts <= decodeFixed(latchFixed);
                        chargingPorts <= decodeCharging(latchChg);
                        state <= ST_STRAP;
                    end
                end
                ST_STRAP: begin
                    // pull-ups are probed live here; only the mode code is latched
                    if (latchCfg == `HBSS_CODE_200K_PU && smbDataNow && smbClkNow) begin
                        smbusSlaveMode <= 1'b1;
                        state <= ST_SOC_CFG;
                    end else begin
                        state <= ST_OTP_CFG;
                    end
                end
                ST_SOC_CFG: begin
                    if (smbWr && smbusWriteAddr == `HBSS_REG_CFG_END) begin
                        state <= ST_OTP_CFG;
                    end
                end
                ST_OTP_CFG: begin
                    configDone <= 1'b1;
                    usbDataDriveEnable <= 1'b1;
                    state <= ST_RUN;
                end
                ST_RUN: begin
                    state <= ST_RUN;
                end
                default: begin
                    state <= ST_STANDBY;
                end
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_gpio
            always @(posedge clk) begin
                if (!reset_n) begin
                    gpioCfg[g] <= `HBSS_ROM_GPIO_CFG;
                    gpioOut[g] <= 1'b0;
                    gpioOe[g] <= 1'b0;
                    gpioPullUp[g] <= 1'b0;
                    gpioPullDown[g] <= 1'b0;
                    gpioLevel[g] <= 1'b0;
                end else begin
                    if (gpioHit && gpioIndex[2:0] == g) begin
                        gpioCfg[g] <= wrData[2:0];
                    end
                    gpioOe[g] <= (gpioCfg[g][1:0] == `HBSS_GPIO_OUT);
                    gpioOut[g] <= gpioCfg[g][`HBSS_GPIO_LVL_BIT];
                    gpioPullDown[g] <= (gpioCfg[g][1:0] == `HBSS_GPIO_IN_PD);
                    gpioPullUp[g] <= (gpioCfg[g][1:0] == `HBSS_GPIO_IN_PU);
                    gpioLevel[g] <= gpioSynced[g];
                end
            end
        end
    endgenerate
endmodule

// [dv/hbss_sequencer_properties.sv]
`timescale 1ns/10ps
module hbss_sequencer_props (
    input wire clk,
    input wire reset_n,
    input wire spiModeStrap,
    input wire smbusWriteValid,
    input wire [7:0] smbusWriteAddr,
    input wire flashAck,
    input wire [7:0] bootStage,
    input wire pllEnable,
    input wire usbDataDriveEnable,
    input wire flashReadReq,
    input wire [15:0] flashReadAddr,
    input wire externalBoot,
    input wire [15:0] execAddr,
    input wire [5:0] portDisabled,
    input wire [5:0] superSpeedDisabled,
    input wire configDone,
    input wire [7:0] gpioOe,
    input wire [7:0] gpioPullUp,
    input wire [7:0] gpioPullDown
);
    wire endWr = smbusWriteValid && smbusWriteAddr == 8'hff;
    standby_outputs_a: assert property (@(posedge clk) !reset_n ##1 !reset_n |-> bootStage == 8'h01
        && !pllEnable && !usbDataDriveEnable && portDisabled == 6'h3f && !flashReadReq && !configDone)
        else $error("standby outputs wrong");
    release_init_a: assert property (@(posedge clk) !reset_n ##1 reset_n |=> pllEnable ##1 bootStage == 8'h02)
        else $error("no init stage after release");
    ss_follow_a: assert property (@(posedge clk) disable iff (!reset_n) (portDisabled & ~superSpeedDisabled) == 6'h00)
        else $error("superspeed left on for disabled port");
    sig_start_a: assert property (@(posedge clk) disable iff (!reset_n) $rose(flashReadReq) |-> flashReadAddr == 16'hfffa)
        else $error("signature read starts at wrong address");
    addr_step_a: assert property (@(posedge clk) disable iff (!reset_n)
        flashReadReq && flashAck && flashReadAddr != 16'hfffd
        |=> !flashReadReq || flashReadAddr == $past(flashReadAddr) + 16'h0001)
        else $error("flash address did not step");
    exec_addr_a: assert property (@(posedge clk) disable iff (!reset_n) externalBoot |-> execAddr == 16'h0000 && !flashReadReq)
        else $error("external boot address wrong");
    no_flash_a: assert property (@(posedge clk) disable iff (!reset_n) !spiModeStrap |-> !flashReadReq)
        else $error("flash read without spi strap");
    cfg_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        bootStage == 8'h20 && !endWr && !$past(endWr) |=> bootStage == 8'h20)
        else $error("controller stage left without end write");
    cfg_end_a: assert property (@(posedge clk) disable iff (!reset_n)
        bootStage == 8'h20 && endWr |-> ##[1:3] bootStage == 8'h40 ##[1:2] bootStage == 8'h80)
        else $error("end write did not finish configuration");
    gpio_pull_a: assert property (@(posedge clk) disable iff (!reset_n) (gpioPullUp & gpioPullDown) == 8'h00
        && (gpioOe & (gpioPullUp | gpioPullDown)) == 8'h00)
        else $error("gpio pull and drive mixed");
endmodule
bind hbss_sequencer hbss_sequencer_props chk (.clk(clk), .reset_n(reset_n), .spiModeStrap(spiModeStrap),
    .smbusWriteValid(smbusWriteValid), .smbusWriteAddr(smbusWriteAddr), .flashAck(flashAck), .bootStage(bootStage),
    .pllEnable(pllEnable), .usbDataDriveEnable(usbDataDriveEnable), .flashReadReq(flashReadReq),
    .flashReadAddr(flashReadAddr), .externalBoot(externalBoot), .execAddr(execAddr), .portDisabled(portDisabled),
    .superSpeedDisabled(superSpeedDisabled), .configDone(configDone), .gpioOe(gpioOe), .gpioPullUp(gpioPullUp),
    .gpioPullDown(gpioPullDown));

// [dv/hbss_flash_model.sv]
`timescale 1ns/10ps
module hbss_flash_model (
    input wire clk,
    input wire flashReadReq,
    input wire [15:0] flashReadAddr,
    input wire [3:0] ackDelay,
    input wire badSig,
    output reg flashAck,
    output reg [7:0] flashData
);
    reg [3:0] waitCnt;
    reg [7:0] sigByte;
    initial begin
        flashAck = 1'b0;
        flashData = 8'h00;
        waitCnt = 4'h0;
    end
    always @* begin
        case (flashReadAddr)
            16'hfffa: sigByte = 8'h32;
            16'hfffb: sigByte = 8'h44;
            16'hfffc: sigByte = badSig ? 8'h47 : 8'h46;
            16'hfffd: sigByte = 8'h55;
            default: sigByte = 8'hff;
        endcase
    end
    // outside an ack the data bus toggles so no stale byte can be mistaken for valid
    always @(posedge clk) begin
        flashAck <= 1'b0;
        flashData <= ~flashData;
        waitCnt <= waitCnt + 4'h1;
        if (!flashReadReq || flashAck) begin
            waitCnt <= 4'h0;
        end else if (waitCnt >= ackDelay) begin
            flashAck <= 1'b1;
            flashData <= sigByte;
        end
    end
endmodule

// [dv/tb_hbss_sequencer.sv]
`timescale 1ns/10ps
module tb_hbss_sequencer;
    reg clk, reset_n, spiModeStrap, sdaPu, sclPu, pllLocked, hostEnumerated, badSig;
    reg smbusWriteValid, bridgeWriteValid, sawCtl;
    reg [5:0] plusDis, minusDis;
    reg [2:0] fixedCode, chgCode, cfgCode;
    reg [7:0] wrAddr, wrData, gpioPinIn;
    reg [3:0] ackDelay;
    wire flashAck, flashReadReq, externalBoot, smbusSlaveMode, configDone, pllEnable, usbDataDriveEnable;
    wire [7:0] flashData, bootStage, gpioOut, gpioOe, gpioPullUp, gpioPullDown, gpioLevel;
    wire [15:0] flashReadAddr, execAddr;
    wire [5:0] portDisabled, superSpeedDisabled, fixedPorts, chargingPorts;
    integer err_count, compares, i;
    hbss_sequencer DUT (.clk(clk), .reset_n(reset_n), .port_plus_line_disable(plusDis),
        .port_minus_line_disable(minusDis), .fixed_port_select_strap(fixedCode), .charging_port_select_strap(chgCode),
        .configStrapCode(cfgCode), .spiModeStrap(spiModeStrap), .smbusDataPullUp(sdaPu), .smbusClockPullUp(sclPu),
        .pllLocked(pllLocked), .flashAck(flashAck), .flashData(flashData), .hostEnumerated(hostEnumerated),
        .smbusWriteValid(smbusWriteValid), .smbusWriteAddr(wrAddr), .smbusWriteData(wrData),
        .bridgeWriteValid(bridgeWriteValid), .bridgeWriteAddr(wrAddr), .bridgeWriteData(wrData),
        .gpioPinIn(gpioPinIn), .bootStage(bootStage), .pllEnable(pllEnable), .usbDataDriveEnable(usbDataDriveEnable),
        .flashReadReq(flashReadReq), .flashReadAddr(flashReadAddr), .externalBoot(externalBoot), .execAddr(execAddr),
        .portDisabled(portDisabled), .superSpeedDisabled(superSpeedDisabled), .fixedPorts(fixedPorts),
        .chargingPorts(chargingPorts), .smbusSlaveMode(smbusSlaveMode), .configDone(configDone), .gpioOut(gpioOut),
        .gpioOe(gpioOe), .gpioPullUp(gpioPullUp), .gpioPullDown(gpioPullDown), .gpioLevel(gpioLevel));
    hbss_flash_model flash (.clk(clk), .flashReadReq(flashReadReq), .flashReadAddr(flashReadAddr),
        .ackDelay(ackDelay), .badSig(badSig), .flashAck(flashAck), .flashData(flashData));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // codes 6 and 7 fall back to the first setting
    function [5:0] fixMask(input [2:0] c);
        fixMask = (c > 3'h5) ? 6'h00 : ((7'h02 << c) - 7'h01) & 6'h3e;
    endfunction
    function [5:0] chgMask(input [2:0] c);
        chgMask = (c > 3'h5) ? 6'h00 : (c == 3'h5) ? 6'h3f : (6'h01 << c) - 6'h01;
    endfunction
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task close_out;
        begin
            $display("compares %0d mismatches %0d", compares, err_count);
            if (err_count == 0 && compares > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    task wait_stage(input [7:0] stage);
        integer n;
        begin
            n = 0;
            sawCtl = 1'b0;
            while (bootStage !== stage && n < 600) begin
                @(negedge clk);
                if (bootStage === 8'h20) sawCtl = 1'b1;
                n = n + 1;
            end
            chk(bootStage, stage);
        end
    endtask
    task boot(input spi, input [2:0] cfg, input [1:0] pu, input [5:0] p, input [5:0] m, input [2:0] fx, input [2:0] cg);
        begin
            @(negedge clk);
            reset_n = 1'b0;
            pllLocked = 1'b0;
            hostEnumerated = 1'b0;
            spiModeStrap = spi;
            cfgCode = cfg;
            sdaPu = pu[0];
            sclPu = pu[1];
            plusDis = p;
            minusDis = m;
            fixedCode = fx;
            chgCode = cg;
            repeat (12) @(negedge clk);
            chk(portDisabled, 6'h3f);
            chk(pllEnable, 16'h0);
            reset_n = 1'b1;
            repeat (20) @(negedge clk);
            chk(bootStage, 8'h02);
            pllLocked = 1'b1;
        end
    endtask
    task wr(input bridge, input [7:0] a, input [7:0] d);
        begin
            @(negedge clk);
            smbusWriteValid = !bridge;
            bridgeWriteValid = bridge;
            wrAddr = a;
            wrData = d;
            @(negedge clk);
            smbusWriteValid = 1'b0;
            bridgeWriteValid = 1'b0;
        end
    endtask
    initial begin
        {reset_n, spiModeStrap, sdaPu, sclPu, pllLocked, hostEnumerated, badSig} = 7'h00;
        {smbusWriteValid, bridgeWriteValid, sawCtl, plusDis, minusDis} = 15'h0000;
        {fixedCode, chgCode, cfgCode, wrAddr, wrData, ackDelay} = 29'h0;
        gpioPinIn = 8'ha5;
        err_count = 0;
        compares = 0;
        for (i = 0; i < 8; i = i + 1) begin
            boot(1'b0, (i == 1) ? 3'h0 : i[2:0], 2'h3, 6'h15 ^ i[5:0], 6'h1c | i[5:0], i[2:0], 3'h7 - i[2:0]);
            wait_stage(8'h80);
            chk(sawCtl, 16'h0);
            chk(portDisabled, (6'h15 ^ i[5:0]) & (6'h1c | i[5:0]));
            chk(superSpeedDisabled, (6'h15 ^ i[5:0]) & (6'h1c | i[5:0]));
            chk(fixedPorts, fixMask(i[2:0]));
            chk(chargingPorts, chgMask(3'h7 - i[2:0]));
        end
        plusDis = 6'h3f;
        minusDis = 6'h3f;
        fixedCode = 3'h5;
        chgCode = 3'h5;
        repeat (10) @(negedge clk);
        chk(portDisabled, 6'h12 & 6'h1f);
        chk(fixedPorts, 6'h00);
        $display("test strap decode done");
        for (i = 0; i < 2; i = i + 1) begin
            badSig = i[0];
            ackDelay = 4'h3 - 4'h3 * i[3:0];
            boot(1'b1, 3'h0, 2'h0, 6'h00, 6'h00, 3'h0, 3'h0);
            wait_stage(8'h80);
            chk(externalBoot, {15'h0, ~i[0]});
            chk(execAddr, 16'h0000);
        end
        $display("test spi signature done");
        boot(1'b0, 3'h1, 2'h1, 6'h00, 6'h00, 3'h0, 3'h0);
        wait_stage(8'h80);
        chk(sawCtl, 16'h0);
        chk(smbusSlaveMode, 16'h0);
        boot(1'b0, 3'h1, 2'h3, 6'h00, 6'h00, 3'h0, 3'h0);
        wait_stage(8'h20);
        chk(smbusSlaveMode, 16'h1);
        repeat (50) @(negedge clk);
        chk(bootStage, 8'h20);
        wr(1'b0, 8'h10, 8'h07);
        wr(1'b1, 8'h11, 8'h03);
        wr(1'b0, 8'hff, 8'h00);
        wait_stage(8'h80);
        chk(configDone, 16'h1);
        chk(usbDataDriveEnable, 16'h1);
        wr(1'b1, 8'h16, 8'h07);
        for (i = 0; i < 4; i = i + 1) begin
            hostEnumerated = 1'b1;
            wr(1'b1, 8'h12 + i[7:0], i[7:0] | ((i == 3) ? 8'h04 : 8'h00));
        end
        wr(1'b0, 8'h30, 8'h07);
        repeat (3) @(negedge clk);
        chk(gpioOe, 8'h21);
        chk(gpioOut, 8'h21);
        chk(gpioPullDown, 8'h08);
        chk(gpioPullUp, 8'h10);
        chk(gpioLevel, 8'ha5);
        $display("test controller config and gpio done");
        close_out;
    end
    initial begin
        #(25 * 20000);
        err_count = err_count + 1;
        close_out;
    end
endmodule
